// file: lds_slave.sv
// What this block does
// - device is slave only; master makes clock, arbitration, start and stop.
// - supports high-speed bus clock up to 3.4 MHz.
// - sda fall with scl high is start, sda rise with scl high is stop.
// - sda change while scl high is a bus condition, not data.
// - 8-bit bytes, one bit per clock, ninth acknowledge bit, any length.
// - acknowledging receiver holds sda low through ack clock high phase.
// - after master nack the device releases sda for stop.
// - device acks address and every written data byte.
// - transfer ends with stop or repeated start.
// - first byte after start is address; default address all zeros.
// - address lsb selects direction: one read, zero write.
// - two low address bits are device select, set by self-address command.
// - shorted key node gives zero, open node gives one.
// - select bits sampled from first key line with segment g and f lines.
// - one self-address command updates all devices; reissue after power loss.
// - after start, match address, capture direction, then drive acknowledge.
// - byte after address in a write is the command byte selecting register.
// - power-up loads defaults, blanks display, enters shutdown.
// - defaults: one digit scanned, decoder off, intensity minimum.
// - shutdown register write with bit 0 zero enters shutdown; digit data kept.
// - shutdown entry or exit clears feature unless bit 7 set.
// - shutdown register at command 0x0C; bit 0 one means normal run.
//
// lds_slave.sv: serial slave port, top of the block.
// assumes clk far faster than the bus clock, key node levels stable.
`timescale 1ns/1ns
`include "lds_map.svh"
module lds_slave (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // self-address key nodes
  input  wire logic        key_return_line_first,
  input  wire logic        segment_g_line,
  input  wire logic        segment_f_line,
  // status towards display core
  output lds_pkg::lds_ctrl_s ctrl,
  output logic      [63:0] digits,
  output logic             shutdown_active,
  output logic             display_blank,
  output logic             key_nodes_reserved,
  output logic      [6:0]  slave_addr
);
  import lds_pkg::*;
  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  lds_bus_s   bus;
  lds_state_e state;
  lds_state_e next_state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [1:0] byte_idx;
  logic       rw;
  logic [7:0] cmd;
  logic       drive_low;
  logic       dev_select_bit_low;
  logic       dev_select_bit_high;
  logic       self_addr_done;
  logic [1:0] node_meta_g;
  logic [1:0] node_meta_f;
  logic       wr_en;
  logic [7:0] rd_data;
  logic       last_sda_rd;
  logic       ack_phase;
  // named decode wires
  wire        byte_done   = bus.scl_rise && (bitcnt == 4'd7);
  // second scl fall in an ack state ends the ninth bit; the first one opens it
  wire        ack_clock   = bus.scl_fall && ack_phase && (state == LDS_RACK || state == LDS_TACK);
  wire [7:0]  rx_byte     = {shreg[6:0], bus.sda};
  wire        addr_match  = rx_byte[7:1] == slave_addr;
  wire        is_addr     = byte_idx == 2'd0;
  wire        is_cmd      = byte_idx == 2'd1;
  wire        master_nack = bus.scl_rise && state == LDS_TACK && bus.sda;
  // device select bits in low address positions
  assign slave_addr         = {5'(`LDS_ADDR_BASE >> 2), dev_select_bit_high, dev_select_bit_low};
  assign shutdown_active    = ~ctrl.shutdown[`LDS_SD_RUN_BIT];
  assign display_blank      = shutdown_active;
  assign key_nodes_reserved = self_addr_done;
  // --------------------------------------------------------------------------
  // pin conditioning
  // --------------------------------------------------------------------------
  // changes during scl high become conditions, handled in lds_sync
  lds_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .bus    (bus)
  );
  // --------------------------------------------------------------------------
  // key node synchroniser for self addressing
  // --------------------------------------------------------------------------
  // nodes read through key return line, shorted pulls it low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      node_meta_g <= 2'h3;
      node_meta_f <= 2'h3;
    end else begin
      node_meta_g <= {node_meta_g[0], segment_g_line & key_return_line_first};
      node_meta_f <= {node_meta_f[0], segment_f_line & key_return_line_first};
    end
  end
  // --------------------------------------------------------------------------
  // protocol state machine
  // --------------------------------------------------------------------------
  // only follows the master's clock; runs off 10 MHz sampling
  always_comb begin
    next_state = state;
    unique case (state)
      LDS_IDLE: next_state = LDS_IDLE;
      LDS_RECV: begin
        if (byte_done) begin
          // mismatch is ignored until next start
          if (is_addr && !addr_match) next_state = LDS_IGNR;
          else                        next_state = LDS_RACK;
        end
      end
      LDS_RACK: if (ack_clock) next_state = (is_addr && rw) ? LDS_SEND : LDS_RECV;
      LDS_SEND: if (byte_done) next_state = LDS_TACK;
      LDS_TACK: begin
        if (master_nack)    next_state = LDS_IGNR;
        else if (ack_clock) next_state = LDS_SEND;
      end
      LDS_IGNR: next_state = LDS_IGNR;
    endcase
    // start and stop override, repeated start reopens
    if (bus.start)     next_state = LDS_RECV;
    else if (bus.stop) next_state = LDS_IDLE;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= LDS_IDLE;
    else        state <= next_state;
  end
  // ninth bit: toggles on each scl fall while in an ack state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_phase <= 1'b0;
    end else if (bus.start || bus.stop) begin
      ack_phase <= 1'b0;
    end else if (bus.scl_fall && (state == LDS_RACK || state == LDS_TACK)) begin
      ack_phase <= ~ack_phase;
    end
  end
  // --------------------------------------------------------------------------
  // bit and byte counters, shift register
  // --------------------------------------------------------------------------
  // eight bits then ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt   <= 4'h0;
      shreg    <= 8'h00;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
    end else if (bus.start) begin
      bitcnt   <= 4'h0;
      byte_idx <= 2'h0;
    end else if (state == LDS_RECV && bus.scl_rise) begin
      shreg  <= rx_byte;
      bitcnt <= byte_done ? 4'h0 : bitcnt + 4'h1;
      if (byte_done && is_addr) rw <= bus.sda;
    end else if (state == LDS_SEND && bus.scl_rise) begin
      bitcnt <= byte_done ? 4'h0 : bitcnt + 4'h1;
    end else if (ack_clock) begin
      if (byte_idx != 2'h2) byte_idx <= byte_idx + 2'h1;
      if (state == LDS_TACK || (state == LDS_RACK && is_addr && rw)) shreg <= rd_data;
    end else if (state == LDS_SEND && bus.scl_fall && bitcnt != 4'h0) begin
      shreg <= {shreg[6:0], 1'b0};
    end
  end
  // --------------------------------------------------------------------------
  // command pointer and write strobe
  // --------------------------------------------------------------------------
  // command byte after address selects register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd   <= 8'h00;
      wr_en <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (state == LDS_RECV && byte_done && !is_addr && !rw) begin
        if (is_cmd) cmd <= rx_byte;
        else        wr_en <= 1'b1;
      end
      // read pointer steps at the end of each sent byte, before the next load
      if (wr_en || (state == LDS_SEND && byte_done)) cmd <= cmd + 8'h01;
    end
  end
  // --------------------------------------------------------------------------
  // self addressing
  // --------------------------------------------------------------------------
  // short gives zero, open gives one; one command updates all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_select_bit_low  <= 1'b0;
      dev_select_bit_high <= 1'b0;
      self_addr_done      <= 1'b0;
    end else if (state == LDS_RECV && byte_done && is_cmd && !rw &&
                 rx_byte == `LDS_CMD_SELFADDR) begin
      dev_select_bit_low  <= node_meta_g[1];
      dev_select_bit_high <= node_meta_f[1];
      self_addr_done      <= 1'b1;
    end
  end
  // --------------------------------------------------------------------------
  // sda drive
  // --------------------------------------------------------------------------
  // ack low across the ninth clock; data bits msb first when sending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_low   <= 1'b0;
      last_sda_rd <= 1'b1;
    end else if (bus.start || bus.stop) begin
      drive_low <= 1'b0;
    end else if (bus.scl_fall) begin
      unique case (next_state)
        LDS_RACK: drive_low <= 1'b1;
        LDS_SEND: drive_low <= ~((state == LDS_SEND) ? shreg[6] : rd_data[7]);
        default:  drive_low <= 1'b0;
      endcase
      last_sda_rd <= 1'b1;
    end else if (state == LDS_RECV && byte_done) begin
      drive_low <= 1'b0;
    end
  end
  // released while master acks or after nack
  assign sda_oe  = drive_low && (state == LDS_RACK || state == LDS_SEND);
  assign sda_out = 1'b0;
  // --------------------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------------------
  lds_regs u_regs (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (wr_en),
    .wr_cmd  (cmd),
    .wr_data (shreg),
    .rd_cmd  (cmd),
    .rd_data (rd_data),
    .ctrl    (ctrl),
    .digits  (digits)
  );
  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_ack_held: assert property (@(posedge clk) disable iff (!rst_n)
    (state == LDS_RACK && bus.scl_rise) |-> sda_oe)
    else $error("ack not driven at ack clock rise");
  a_no_ack_mis: assert property (@(posedge clk) disable iff (!rst_n)
    (state == LDS_RECV && byte_done && is_addr && !addr_match && !bus.start) |=> state == LDS_IGNR)
    else $error("mismatched address not ignored");
  a_ignore_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state == LDS_IGNR |-> !sda_oe)
    else $error("driving sda while ignoring");
  a_start_recv: assert property (@(posedge clk) disable iff (!rst_n)
    bus.start |=> state == LDS_RECV && bitcnt == 4'h0)
    else $error("start not detected");
  a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.stop && !bus.start) |=> state == LDS_IDLE)
    else $error("stop did not release");
  a_nack_release: assert property (@(posedge clk) disable iff (!rst_n)
    (master_nack && !bus.start && !bus.stop) |=> !sda_oe [*2])
    else $error("sda held after master nack");
  a_match_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (state == LDS_RECV && byte_done && !bus.start) |=> (state == LDS_RACK) == $past(!is_addr || addr_match))
    else $error("ack decision wrong");
  a_dir_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (state == LDS_RECV && byte_done && is_addr && !bus.start) |=> rw == $past(bus.sda))
    else $error("direction bit not captured");
  a_write_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en |-> !rw && byte_idx == 2'h2)
    else $error("write strobe outside data phase");
endmodule : lds_slave

// file: lds_map.svh
// lds_map.svh: offsets, field positions, reset values and timing counts of the
// LED driver serial slave port. assumes inclusion by bare name.
`ifndef LDS_MAP_SVH
`define LDS_MAP_SVH
// --------------------------------------------------------------------------
// addresses and command bytes
// --------------------------------------------------------------------------
`define LDS_ADDR_BASE     7'h00
`define LDS_CMD_DIGIT0    8'h01
`define LDS_CMD_DIGIT7    8'h08
`define LDS_CMD_DECODE    8'h09
`define LDS_CMD_INTENS    8'h0A
`define LDS_CMD_SCANLIM   8'h0B
`define LDS_CMD_SHUTDOWN  8'h0C
`define LDS_CMD_SELFADDR  8'h2D
`define LDS_CMD_FEATURE   8'h0E
// --------------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------------
`define LDS_SD_RUN_BIT    0
`define LDS_SD_KEEP_BIT   7
`define LDS_RST_SHUTDOWN  8'h00
`define LDS_RST_FEATURE   8'h00
`define LDS_RST_DECODE    8'h00
`define LDS_RST_INTENS    8'h00
`define LDS_RST_SCANLIM   8'h00
`define LDS_RST_DIGIT     8'h00
// --------------------------------------------------------------------------
// timing: fastest supported bus clock
// --------------------------------------------------------------------------
`define LDS_HS_CLK_KHZ    3400
`endif

// file: lds_pkg.sv
// lds_pkg.sv: types of the LED driver serial slave port.
// assumes lds_map.svh is available for the constants.
package lds_pkg;
  // bus protocol states, gray coded along the usual path
  typedef enum logic [2:0] {
    LDS_IDLE = 3'b000,
    LDS_RECV = 3'b001,
    LDS_RACK = 3'b011,
    LDS_SEND = 3'b010,
    LDS_TACK = 3'b110,
    LDS_IGNR = 3'b111
  } lds_state_e;
  // register bank seen by the display core
  typedef struct packed {
    logic [7:0] decode;
    logic [7:0] intensity;
    logic [7:0] scan_limit;
    logic [7:0] shutdown;
    logic [7:0] feature;
  } lds_ctrl_s;
  // conditioned bus lines
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } lds_bus_s;
endpackage : lds_pkg

// file: lds_sync.sv
// lds_sync.sv: two-flop synchroniser and condition detector for the bus pins.
// assumes pins are asynchronous to clk and sampled much faster than scl.
`timescale 1ns/1ns
module lds_sync (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // raw pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // conditioned events
  output lds_pkg::lds_bus_s bus
);
  import lds_pkg::*;
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic       scl_q;
  logic       sda_q;
  // ------------------------------------------------------------------------
  // synchroniser and one-cycle history
  // ------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_q    <= scl_meta[1];
      sda_q    <= sda_meta[1];
    end
  end
  // edge and condition decode
  assign bus.scl_rise = scl_meta[1] & ~scl_q;
  assign bus.scl_fall = ~scl_meta[1] & scl_q;
  assign bus.start    = scl_meta[1] & scl_q & sda_q & ~sda_meta[1];
  assign bus.stop     = scl_meta[1] & scl_q & ~sda_q & sda_meta[1];
  assign bus.sda      = sda_meta[1];
endmodule : lds_sync

// file: lds_regs.sv
// lds_regs.sv: control register bank with shutdown side effects and digit store.
// assumes one-cycle write strobes from the protocol engine.
`timescale 1ns/1ns
`include "lds_map.svh"
module lds_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_cmd,
  input  wire logic [7:0]  wr_data,
  // read port
  input  wire logic [7:0]  rd_cmd,
  output logic      [7:0]  rd_data,
  // register contents
  output lds_pkg::lds_ctrl_s ctrl,
  output logic      [63:0] digits
);
  import lds_pkg::*;
  wire       wr_sd   = wr_en && (wr_cmd == `LDS_CMD_SHUTDOWN);
  wire       wr_feat = wr_en && (wr_cmd == `LDS_CMD_FEATURE);
  wire       is_dig_w = (wr_cmd >= `LDS_CMD_DIGIT0) && (wr_cmd <= `LDS_CMD_DIGIT7);
  wire [2:0] dig_w   = 3'(wr_cmd - `LDS_CMD_DIGIT0);
  wire       is_dig_r = (rd_cmd >= `LDS_CMD_DIGIT0) && (rd_cmd <= `LDS_CMD_DIGIT7);
  wire [2:0] dig_r   = 3'(rd_cmd - `LDS_CMD_DIGIT0);
  // ------------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------------
  // power-up defaults, minimum settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.decode     <= `LDS_RST_DECODE;
      ctrl.intensity  <= `LDS_RST_INTENS;
      ctrl.scan_limit <= `LDS_RST_SCANLIM;
      ctrl.shutdown   <= `LDS_RST_SHUTDOWN;
      ctrl.feature    <= `LDS_RST_FEATURE;
    end else if (wr_en) begin
      if (wr_cmd == `LDS_CMD_DECODE)  ctrl.decode     <= wr_data;
      if (wr_cmd == `LDS_CMD_INTENS)  ctrl.intensity  <= wr_data;
      if (wr_cmd == `LDS_CMD_SCANLIM) ctrl.scan_limit <= wr_data;
      if (wr_sd) ctrl.shutdown <= wr_data;
      // feature cleared unless keep bit set
      if (wr_sd && !wr_data[`LDS_SD_KEEP_BIT]) ctrl.feature <= `LDS_RST_FEATURE;
      else if (wr_feat)                         ctrl.feature <= wr_data;
    end
  end
  // digit store, kept through shutdown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digits <= {8{`LDS_RST_DIGIT}};
    end else if (wr_en && is_dig_w) begin
      digits[dig_w*8 +: 8] <= wr_data;
    end
  end
  // read mux
  assign rd_data = is_dig_r                        ? digits[dig_r*8 +: 8] :
                   (rd_cmd == `LDS_CMD_DECODE)    ? ctrl.decode :
                   (rd_cmd == `LDS_CMD_INTENS)    ? ctrl.intensity :
                   (rd_cmd == `LDS_CMD_SCANLIM)   ? ctrl.scan_limit :
                   (rd_cmd == `LDS_CMD_SHUTDOWN)  ? ctrl.shutdown :
                   (rd_cmd == `LDS_CMD_FEATURE)   ? ctrl.feature : 8'h00;
  // shutdown register run bit tied to a shutdown write
  a_sd_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_sd |=> ctrl.shutdown[`LDS_SD_RUN_BIT] == $past(wr_data[`LDS_SD_RUN_BIT]))
    else $error("shutdown run bit not stored");
  a_feat_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_sd && !wr_data[`LDS_SD_KEEP_BIT]) |=> ctrl.feature == 8'h00)
    else $error("feature not cleared on shutdown write");
  a_feat_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_sd && wr_data[`LDS_SD_KEEP_BIT]) |=> $stable(ctrl.feature))
    else $error("feature changed with keep bit set");
endmodule : lds_regs

// file: lds_bus_master.sv
// lds_bus_master.sv: bus master model that makes scl, start, stop and bits.
// assumes a pull-up on sda; the bench resolves the wire from all drivers.
`timescale 1ns/1ns
module lds_bus_master (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // ------------------------------------------------------------
  // idle and timing
  // ------------------------------------------------------------
  // idle lines high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // waits a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // ------------------------------------------------------------
  // bit and condition tasks
  // ------------------------------------------------------------
  // data steady in scl high
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    s = sda_line;
    tick(2);
    scl <= 1'b0;
  endtask : bit_io
  task automatic start();
    tick(2);
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_drv <= 1'b1;
    tick(4);
  endtask : stop
  // byte msb first, ninth bit released
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic m_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~m_ack, s);
  endtask : rbyte
endmodule : lds_bus_master

// file: testbench.sv
// testbench.sv: self-checking bench for the serial slave port.
// assumes lds_bus_master as the far side and a pull-up on sda.
`timescale 1ns/1ns
module testbench;
  import lds_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic key = 1'b1;
  logic seg_g = 1'b0;
  logic seg_f = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda_oe;
  logic sda_out;
  logic sda_line;
  lds_ctrl_s ctrl;
  logic [63:0] digits;
  logic sd_act;
  logic blank;
  logic reserved;
  logic [6:0] addr;
  int failures = 0;
  int comparisons = 0;
  // ------------------------------------------------------------
  // clock, wire and instances
  // ------------------------------------------------------------
  // clock of 100 ns
  always #50 clk = ~clk;
  // pull-up wire, low while the slave pulls it
  assign sda_line = sda_drv & ~sda_oe;
  lds_slave i_lds_slave (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .key_return_line_first(key),
    .segment_g_line(seg_g), .segment_f_line(seg_f), .ctrl(ctrl), .digits(digits),
    .shutdown_active(sd_act), .display_blank(blank), .key_nodes_reserved(reserved),
    .slave_addr(addr));
  lds_bus_master i_lds_bus_master (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  // ------------------------------------------------------------
  // check and transfer tasks
  // ------------------------------------------------------------
  // compares one value
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // write: address, command, n data bytes, each ack compared
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
                    input int n, input logic exp_ack);
    logic ack;
    i_lds_bus_master.start();
    i_lds_bus_master.wbyte({a, 1'b0}, ack);
    check(ack, exp_ack);
    i_lds_bus_master.wbyte(cmd, ack);
    check(ack, exp_ack);
    for (int i = 0; i < n; i++) begin
      i_lds_bus_master.wbyte(d[15-8*i -: 8], ack);
      check(ack, exp_ack);
    end
    i_lds_bus_master.stop();
  endtask : wr
  // read two bytes from cmd after a repeated start
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    logic ack;
    logic [7:0] b;
    i_lds_bus_master.start();
    i_lds_bus_master.wbyte(8'h00, ack);
    i_lds_bus_master.wbyte(cmd, ack);
    i_lds_bus_master.start();
    i_lds_bus_master.wbyte(8'h01, ack);
    check(ack, 1'b1);
    i_lds_bus_master.rbyte(1'b1, b);
    check(b, exp[15:8]);
    i_lds_bus_master.rbyte(1'b0, b);
    check(b, exp[7:0]);
    i_lds_bus_master.tick(4);
    check(sda_oe, 1'b0);
    i_lds_bus_master.stop();
  endtask : rd
  // prints counts and verdict, ends the run
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(ctrl, 40'h00_00_00_00_00);
    check({sd_act, blank}, 2'b11);
    check(addr, 7'h00);
    wr(7'h00, 8'h01, 16'hA55A, 2, 1'b1);
    check(digits[15:0], 16'h5AA5);
    wr(7'h00, 8'h0E, 16'h5500, 1, 1'b1);
    wr(7'h00, 8'h0C, 16'h8000, 1, 1'b1);
    check(ctrl.feature, 8'h55);
    check({sd_act, digits[15:0]}, 17'h15AA5);
    wr(7'h00, 8'h0C, 16'h0100, 1, 1'b1);
    check(ctrl.feature, 8'h00);
    check({sd_act, blank, ctrl.shutdown}, 10'h001);
    rd(8'h01, 16'hA55A);
    wr(7'h05, 8'h01, 16'hFF00, 1, 1'b0);
    check(digits[15:0], 16'h5AA5);
    wr(7'h00, 8'h2D, 16'h0000, 0, 1'b1);
    check(addr, 7'h02);
    check(reserved, 1'b1);
    wr(7'h00, 8'h01, 16'h3300, 1, 1'b0);
    check(digits[7:0], 8'hA5);
    wr(7'h02, 8'h01, 16'h3300, 1, 1'b1);
    check(digits[7:0], 8'h33);
    final_report();
  end
  // watchdog, far beyond the expected 2278 cycles
  initial begin
    #2000000;
    failures++;
    final_report();
  end
endmodule : testbench
